// [rtl/dbuc_top.sv]
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module dbuc_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [dbuc_pkg::AW-1:0] addr,
    input wire logic [dbuc_pkg::DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic io_update,
    output logic [dbuc_pkg::DW-1:0] rdata,
    output logic update_pending,
    output logic mult_enable,
    output logic [dbuc_pkg::FACW-1:0] mult_factor,
    output logic [dbuc_pkg::PUMPW-1:0] pump_current_select,
    output logic oscillator_range_select,
    output logic [dbuc_pkg::SYSW-1:0] sys_freq_khz,
    output logic [dbuc_pkg::NCH*dbuc_pkg::ACCW-1:0] phase_acc,
    output logic [dbuc_pkg::NCH*dbuc_pkg::ACCW-1:0] sweep_acc
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        dbuc_pkg::dbuc_cfg_s buf_cfg;
        dbuc_pkg::dbuc_cfg_s act_cfg;
        logic [dbuc_pkg::DW-1:0] rdata;
        logic pending;
        logic mult_en;
        logic [dbuc_pkg::SYSW-1:0] sys_freq;
        logic pulse_ph;
        logic pulse_sw;
    } dbuc_state_s;

    dbuc_state_s s_q;
    dbuc_state_s s_d;

    logic [dbuc_pkg::AW-1:0] addr_w;
    logic [1:0] ch_sel;
    logic [3:0] page;
    logic upd_write;
    logic upd_event;
    logic buf_write;
    logic [dbuc_pkg::FACW-1:0] fac_in;
    logic [dbuc_pkg::SYSW-1:0] ref_wide;
    logic [dbuc_pkg::SYSW-1:0] fac_wide;
    logic [dbuc_pkg::SYSW-1:0] sys_calc;

    assign addr_w = {addr[dbuc_pkg::AW-1:2], 2'b00};
    assign ch_sel = addr[3:2];
    assign page = addr[7:4];

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        buf_write = 1'b0;
        upd_write = 1'b0;
        fac_in = wdata[dbuc_pkg::CFG_FACTOR_LSB +: dbuc_pkg::FACW];
        ref_wide = '0;
        fac_wide = '0;
        sys_calc = '0;

        // Buffer writes: nothing here touches the active copy
        if (wr) begin
            case (addr_w)
                dbuc_pkg::ADDR_CLK_CFG: begin
                    // Out-of-range factors fall back to bypass rather than
                    // driving the loop at an unsupported ratio
                    if (fac_in >= dbuc_pkg::FACTOR_MIN && fac_in <= dbuc_pkg::FACTOR_MAX) begin
                        s_d.buf_cfg.factor = fac_in;
                    end else begin
                        s_d.buf_cfg.factor = dbuc_pkg::FACTOR_RST;
                    end
                    s_d.buf_cfg.pump =
                        wdata[dbuc_pkg::CFG_PUMP_LSB +: dbuc_pkg::PUMPW];
                    s_d.buf_cfg.range = wdata[dbuc_pkg::CFG_RANGE_BIT];
                    buf_write = 1'b1;
                end
                dbuc_pkg::ADDR_ACC_CTL: begin
                    s_d.buf_cfg.auto_ph = wdata[dbuc_pkg::ACC_AUTO_PH_BIT];
                    s_d.buf_cfg.clr_ph = wdata[dbuc_pkg::ACC_CLR_PH_BIT];
                    s_d.buf_cfg.auto_sw = wdata[dbuc_pkg::ACC_AUTO_SW_BIT];
                    s_d.buf_cfg.clr_sw = wdata[dbuc_pkg::ACC_CLR_SW_BIT];
                    buf_write = 1'b1;
                end
                dbuc_pkg::ADDR_REF_FREQ: begin
                    s_d.buf_cfg.ref_freq = wdata[dbuc_pkg::REFW-1:0];
                    buf_write = 1'b1;
                end
                dbuc_pkg::ADDR_UPDATE: begin
                    upd_write = wdata[dbuc_pkg::UPDATE_BIT];
                end
                default: begin
                    if (page == dbuc_pkg::PAGE_FTW) begin
                        s_d.buf_cfg.ftw[ch_sel] = wdata;
                        buf_write = 1'b1;
                    end else if (page == dbuc_pkg::PAGE_STEP) begin
                        s_d.buf_cfg.step[ch_sel] = wdata;
                        buf_write = 1'b1;
                    end
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Update event: pin strobe or register command
        // --------------------------------------------------------------------
        upd_event = io_update | upd_write;
        s_d.pulse_ph = 1'b0;
        s_d.pulse_sw = 1'b0;
        if (upd_event) begin
            // The old buffer moves; a write in the same cycle stays pending
            s_d.act_cfg = s_q.buf_cfg;
            s_d.pulse_ph = s_q.buf_cfg.auto_ph;
            s_d.pulse_sw = s_q.buf_cfg.auto_sw;
        end

        // A buffer write in the update cycle keeps the flag set
        if (buf_write) begin
            s_d.pending = 1'b1;
        end else if (upd_event) begin
            s_d.pending = 1'b0;
        end

        // --------------------------------------------------------------------
        // System clock figure from the active settings
        // --------------------------------------------------------------------
        s_d.mult_en = (s_d.act_cfg.factor != dbuc_pkg::FACTOR_RST);
        ref_wide = {{dbuc_pkg::FACW{1'b0}}, s_d.act_cfg.ref_freq};
        fac_wide = {{dbuc_pkg::REFW{1'b0}}, s_d.act_cfg.factor};
        if (s_d.mult_en) begin
            sys_calc = dbuc_pkg::SYSW'(ref_wide * fac_wide);
        end else begin
            sys_calc = ref_wide;
        end
        s_d.sys_freq = sys_calc;

        // --------------------------------------------------------------------
        // Readback: active copy only, data valid in the next cycle only
        // --------------------------------------------------------------------
        s_d.rdata = '0;
        if (rd) begin
            case (addr_w)
                dbuc_pkg::ADDR_CLK_CFG: begin
                    s_d.rdata[dbuc_pkg::CFG_FACTOR_LSB +: dbuc_pkg::FACW] =
                        s_q.act_cfg.factor;
                    s_d.rdata[dbuc_pkg::CFG_PUMP_LSB +: dbuc_pkg::PUMPW] =
                        s_q.act_cfg.pump;
                    s_d.rdata[dbuc_pkg::CFG_RANGE_BIT] = s_q.act_cfg.range;
                end
                dbuc_pkg::ADDR_ACC_CTL: begin
                    s_d.rdata[dbuc_pkg::ACC_AUTO_PH_BIT] = s_q.act_cfg.auto_ph;
                    s_d.rdata[dbuc_pkg::ACC_CLR_PH_BIT] = s_q.act_cfg.clr_ph;
                    s_d.rdata[dbuc_pkg::ACC_AUTO_SW_BIT] = s_q.act_cfg.auto_sw;
                    s_d.rdata[dbuc_pkg::ACC_CLR_SW_BIT] = s_q.act_cfg.clr_sw;
                end
                dbuc_pkg::ADDR_REF_FREQ: begin
                    s_d.rdata[dbuc_pkg::REFW-1:0] = s_q.act_cfg.ref_freq;
                end
                dbuc_pkg::ADDR_SYS_FREQ: begin
                    s_d.rdata[dbuc_pkg::SYSW-1:0] = s_q.sys_freq;
                end
                dbuc_pkg::ADDR_STATUS: begin
                    s_d.rdata[dbuc_pkg::STAT_PENDING_BIT] = s_q.pending;
                    s_d.rdata[dbuc_pkg::STAT_MULT_EN_BIT] = s_q.mult_en;
                end
                default: begin
                    if (page == dbuc_pkg::PAGE_FTW) begin
                        s_d.rdata = s_q.act_cfg.ftw[ch_sel];
                    end else if (page == dbuc_pkg::PAGE_STEP) begin
                        s_d.rdata = s_q.act_cfg.step[ch_sel];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q.buf_cfg <= dbuc_pkg::CFG_RST;
            s_q.act_cfg <= dbuc_pkg::CFG_RST;
            s_q.rdata <= '0;
            s_q.pending <= 1'b0;
            s_q.mult_en <= 1'b0;
            s_q.sys_freq <= {{dbuc_pkg::FACW{1'b0}}, dbuc_pkg::REF_FREQ_RST};
            s_q.pulse_ph <= 1'b0;
            s_q.pulse_sw <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Channel accumulators
    // ------------------------------------------------------------------------
    // Clear controls are chip-wide and reach every channel in the same edge
    for (genvar ch = 0; ch < dbuc_pkg::NCH; ch++) begin : g_chan
        dbuc_acc u_phase (
            .mclk(mclk),
            .reset(reset),
            .step(s_q.act_cfg.ftw[ch]),
            .clear_hold(s_q.act_cfg.clr_ph),
            .clear_pulse(s_q.pulse_ph),
            .acc(phase_acc[ch*dbuc_pkg::ACCW +: dbuc_pkg::ACCW])
        );
        dbuc_acc u_sweep (
            .mclk(mclk),
            .reset(reset),
            .step(s_q.act_cfg.step[ch]),
            .clear_hold(s_q.act_cfg.clr_sw),
            .clear_pulse(s_q.pulse_sw),
            .acc(sweep_acc[ch*dbuc_pkg::ACCW +: dbuc_pkg::ACCW])
        );
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign rdata = s_q.rdata;
    assign update_pending = s_q.pending;
    assign mult_enable = s_q.mult_en;
    assign mult_factor = s_q.act_cfg.factor;
    assign pump_current_select = s_q.act_cfg.pump;
    assign oscillator_range_select = s_q.act_cfg.range;
    assign sys_freq_khz = s_q.sys_freq;

endmodule // dbuc_top

// [rtl/dbuc_pkg.sv]
// ----------------------------------------------------------------------------
// Buffered update control: shared constants and types
// ----------------------------------------------------------------------------
package dbuc_pkg;

    localparam int NCH = 4;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int ACCW = 32;
    localparam int FACW = 5;
    localparam int PUMPW = 2;
    localparam int REFW = 20;
    localparam int SYSW = REFW + FACW;

    // ------------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_CLK_CFG = 8'h00;
    localparam logic [AW-1:0] ADDR_ACC_CTL = 8'h04;
    localparam logic [AW-1:0] ADDR_UPDATE = 8'h08;
    localparam logic [AW-1:0] ADDR_REF_FREQ = 8'h0c;
    localparam logic [AW-1:0] ADDR_SYS_FREQ = 8'h10;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h14;
    localparam logic [3:0] PAGE_FTW = 4'h2;
    localparam logic [3:0] PAGE_STEP = 4'h3;

    // ------------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------------
    localparam int CFG_FACTOR_LSB = 0;
    localparam int CFG_PUMP_LSB = 5;
    localparam int CFG_RANGE_BIT = 7;
    localparam int ACC_AUTO_PH_BIT = 0;
    localparam int ACC_CLR_PH_BIT = 1;
    localparam int ACC_AUTO_SW_BIT = 2;
    localparam int ACC_CLR_SW_BIT = 3;
    localparam int UPDATE_BIT = 0;
    localparam int STAT_PENDING_BIT = 0;
    localparam int STAT_MULT_EN_BIT = 1;

    // ------------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------------
    localparam logic [FACW-1:0] FACTOR_RST = 5'h00;
    localparam logic [FACW-1:0] FACTOR_MIN = 5'h04;
    localparam logic [FACW-1:0] FACTOR_MAX = 5'h14;
    localparam logic [PUMPW-1:0] PUMP_RST = 2'h0;
    localparam logic RANGE_RST = 1'b0;
    localparam logic [REFW-1:0] REF_FREQ_RST = 20'h7a120;
    localparam logic [ACCW-1:0] WORD_RST = 32'h0000_0000;

    typedef struct packed {
        logic [FACW-1:0] factor;
        logic [PUMPW-1:0] pump;
        logic range;
        logic auto_ph;
        logic clr_ph;
        logic auto_sw;
        logic clr_sw;
        logic [REFW-1:0] ref_freq;
        logic [NCH-1:0][ACCW-1:0] ftw;
        logic [NCH-1:0][ACCW-1:0] step;
    } dbuc_cfg_s;

    localparam dbuc_cfg_s CFG_RST = '{
        factor: FACTOR_RST,
        pump: PUMP_RST,
        range: RANGE_RST,
        auto_ph: 1'b0,
        clr_ph: 1'b0,
        auto_sw: 1'b0,
        clr_sw: 1'b0,
        ref_freq: REF_FREQ_RST,
        ftw: '0,
        step: '0
    };

endpackage

// [rtl/dbuc_acc.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// One accumulator with hold-clear and one-cycle auto-clear
// ----------------------------------------------------------------------------
module dbuc_acc (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [dbuc_pkg::ACCW-1:0] step,
    input wire logic clear_hold,
    input wire logic clear_pulse,
    output logic [dbuc_pkg::ACCW-1:0] acc
);

    typedef struct packed {
        logic [dbuc_pkg::ACCW-1:0] acc;
    } dbuc_acc_s;

    dbuc_acc_s s_q;
    dbuc_acc_s s_d;

    always_comb begin
        s_d = s_q;
        if (clear_hold) begin
            s_d.acc = dbuc_pkg::WORD_RST;
        end else if (clear_pulse) begin
            // Zero for one edge only, then accumulation resumes
            s_d.acc = dbuc_pkg::WORD_RST;
        end else begin
            s_d.acc = s_q.acc + step;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign acc = s_q.acc;

endmodule // dbuc_acc

// [sim/dbuc_top_properties.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Port-level properties of the buffered update control
// ----------------------------------------------------------------------------
module dbuc_top_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [dbuc_pkg::AW-1:0] addr,
    input wire logic [dbuc_pkg::DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic io_update,
    input wire logic [dbuc_pkg::DW-1:0] rdata,
    input wire logic update_pending,
    input wire logic mult_enable,
    input wire logic [dbuc_pkg::FACW-1:0] mult_factor,
    input wire logic [dbuc_pkg::PUMPW-1:0] pump_current_select,
    input wire logic oscillator_range_select,
    input wire logic [dbuc_pkg::SYSW-1:0] sys_freq_khz,
    input wire logic [dbuc_pkg::NCH*dbuc_pkg::ACCW-1:0] phase_acc,
    input wire logic [dbuc_pkg::NCH*dbuc_pkg::ACCW-1:0] sweep_acc
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic upd_now;
    // Either strobe path counts as an update event
    // Low address bits are ignored by the decoder, so compare the word address only
    assign upd_now = io_update || (wr && addr[7:2] == dbuc_pkg::ADDR_UPDATE[7:2]
        && wdata[dbuc_pkg::UPDATE_BIT]);

    rdata_idle_a: assert property (!$past(rd) |-> rdata == '0)
        else $error("read data not zero outside its slot");
    pending_set_a: assert property (wr && addr == dbuc_pkg::ADDR_CLK_CFG |=> update_pending)
        else $error("buffered write did not raise pending");
    pending_clear_a: assert property (io_update && !wr |=> !update_pending)
        else $error("update did not clear pending");
    active_hold_a: assert property (!upd_now |=> $stable(mult_factor)
        && $stable(pump_current_select) && $stable(oscillator_range_select))
        else $error("active clock setting changed without update");
    freq_hold_a: assert property ($changed(sys_freq_khz) |-> $past(upd_now))
        else $error("system frequency changed without update");
    enable_match_a: assert property (mult_enable == (mult_factor != '0))
        else $error("multiplier enable disagrees with factor");
    factor_range_a: assert property (mult_factor == '0 || (mult_factor >= dbuc_pkg::FACTOR_MIN
        && mult_factor <= dbuc_pkg::FACTOR_MAX))
        else $error("active factor outside allowed range");
    clear_all_a: assert property ($past(phase_acc[31:0]) != '0 && phase_acc[31:0] == '0
        |-> phase_acc == '0)
        else $error("phase clear did not reach every channel");
    sweep_all_a: assert property ($past(sweep_acc[31:0]) != '0 && sweep_acc[31:0] == '0
        |-> sweep_acc == '0)
        else $error("sweep clear did not reach every channel");

    cover property (io_update);
    cover property (rd ##1 rdata != '0);
    cover property ($rose(mult_enable));
    cover property ($past(sweep_acc) != '0 && sweep_acc == '0);
endmodule // dbuc_top_properties

bind dbuc_top dbuc_top_properties i_props (.mclk(mclk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .io_update(io_update), .rdata(rdata),
    .update_pending(update_pending), .mult_enable(mult_enable), .mult_factor(mult_factor),
    .pump_current_select(pump_current_select),
    .oscillator_range_select(oscillator_range_select), .sys_freq_khz(sys_freq_khz),
    .phase_acc(phase_acc), .sweep_acc(sweep_acc));

// [sim/dbuc_host.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Host controller model: register writes, reads and update strobes
// ----------------------------------------------------------------------------
module dbuc_host (
    input wire logic mclk,
    input wire logic [dbuc_pkg::DW-1:0] rdata,
    output logic [dbuc_pkg::AW-1:0] addr,
    output logic [dbuc_pkg::DW-1:0] wdata,
    output logic wr,
    output logic rd,
    output logic io_update
);
    int ref_khz = 500000;
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        io_update = 1'b0;
    end
    // Released lines show the inverse so a stale value never looks valid
    task automatic write_reg(input logic [dbuc_pkg::AW-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic read_reg(input logic [dbuc_pkg::AW-1:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
    task automatic set_ref(input int f);
        ref_khz = (f > 500000) ? 500000 : f;
        write_reg(dbuc_pkg::ADDR_REF_FREQ, 32'(ref_khz));
    endtask
    task automatic set_clock(input logic [4:0] f, input logic [1:0] p, output logic r);
        r = (f != 0) && (ref_khz * f > 255000);
        write_reg(dbuc_pkg::ADDR_CLK_CFG, {24'h0, r, p, f});
    endtask
    // Updates are held back until the host asks, so channels change together
    task automatic pulse_update(input logic by_reg);
        if (by_reg) begin
            write_reg(dbuc_pkg::ADDR_UPDATE, 32'h0000_0001);
        end else begin
            @(posedge mclk);
            io_update <= 1'b1;
            @(posedge mclk);
            io_update <= 1'b0;
        end
    endtask
endmodule // dbuc_host

// [sim/dbuc_top_bench.sv]
`timescale 1ns/10ps
`define CHECK(g, e) check_eq(32'(g), 32'(e))
module dbuc_top_bench;
    logic mclk;
    logic reset;
    logic [dbuc_pkg::AW-1:0] addr;
    logic [dbuc_pkg::DW-1:0] wdata;
    logic wr;
    logic rd;
    logic io_update;
    logic [dbuc_pkg::DW-1:0] rdata;
    logic update_pending;
    logic mult_enable;
    logic [dbuc_pkg::FACW-1:0] mult_factor;
    logic [dbuc_pkg::PUMPW-1:0] pump_current_select;
    logic oscillator_range_select;
    logic [dbuc_pkg::SYSW-1:0] sys_freq_khz;
    logic [dbuc_pkg::NCH*dbuc_pkg::ACCW-1:0] phase_acc;
    logic [dbuc_pkg::NCH*dbuc_pkg::ACCW-1:0] sweep_acc;
    int fail_count;
    int n_tests;
    logic [31:0] rd_val;
    logic [31:0] snap [4];
    logic rng;
    int fac [4] = '{20, 21, 3, 0};
    int exp_fac [4] = '{20, 0, 0, 0};

    dbuc_top i_dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .io_update(io_update), .rdata(rdata), .update_pending(update_pending),
        .mult_enable(mult_enable), .mult_factor(mult_factor),
        .pump_current_select(pump_current_select),
        .oscillator_range_select(oscillator_range_select), .sys_freq_khz(sys_freq_khz),
        .phase_acc(phase_acc), .sweep_acc(sweep_acc));
    dbuc_host i_host (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .io_update(io_update));

    function automatic logic [31:0] ph(int i);
        return phase_acc[i*32 +: 32];
    endfunction
    function automatic logic [31:0] sw(int i);
        return sweep_acc[i*32 +: 32];
    endfunction
    // Odd words so no channel wraps back to zero during the run
    function automatic logic [31:0] ftw_of(int i);
        return 32'h0001_0003 + 32'(i) * 32'h0000_0202;
    endfunction
    function automatic logic [31:0] step_of(int i);
        return 32'h0000_0011 + 32'(i);
    endfunction
    task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        close_out();
    end
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        fail_count = 0;
        n_tests = 0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        #1;
        `CHECK(mult_factor, dbuc_pkg::FACTOR_RST);
        `CHECK(pump_current_select, dbuc_pkg::PUMP_RST);
        `CHECK(sys_freq_khz, dbuc_pkg::REF_FREQ_RST);
        `CHECK(|{phase_acc, sweep_acc}, 0);
        i_host.set_ref(100000);
        i_host.set_clock(5'h04, 2'h2, rng);
        #1;
        `CHECK(mult_factor, 0);
        `CHECK(sys_freq_khz, dbuc_pkg::REF_FREQ_RST);
        `CHECK(update_pending, 1);
        i_host.read_reg(dbuc_pkg::ADDR_CLK_CFG, rd_val);
        `CHECK(rd_val, 0);
        i_host.pulse_update(1'b0);
        #1;
        `CHECK(update_pending, 0);
        `CHECK(sys_freq_khz, 400000);
        `CHECK(oscillator_range_select, rng);
        i_host.read_reg(dbuc_pkg::ADDR_CLK_CFG, rd_val);
        `CHECK(rd_val, {rng, 2'h2, 5'h04});
        i_host.read_reg(dbuc_pkg::ADDR_STATUS, rd_val);
        `CHECK(rd_val, 2);
        i_host.read_reg(dbuc_pkg::ADDR_REF_FREQ, rd_val);
        `CHECK(rd_val, 100000);
        i_host.read_reg(dbuc_pkg::ADDR_SYS_FREQ, rd_val);
        `CHECK(rd_val, 400000);
        i_host.read_reg(8'h40, rd_val);
        `CHECK(rd_val, 0);
        for (int k = 0; k < 4; k++) begin
            i_host.set_clock(5'(fac[k]), 2'(k), rng);
            i_host.pulse_update(k[0]);
            #1;
            `CHECK(mult_factor, exp_fac[k]);
            `CHECK(mult_enable, exp_fac[k] != 0);
            `CHECK(pump_current_select, k);
            `CHECK(oscillator_range_select, rng);
            `CHECK(update_pending, 0);
            `CHECK(sys_freq_khz, (exp_fac[k] == 0) ? 100000 : 100000 * exp_fac[k]);
        end
        for (int i = 0; i < 4; i++) begin
            i_host.write_reg(8'h20 + 8'(4 * i), ftw_of(i));
            i_host.write_reg(8'h30 + 8'(4 * i), step_of(i));
        end
        i_host.write_reg(dbuc_pkg::ADDR_ACC_CTL, 32'h0000_0001);
        i_host.pulse_update(1'b0);
        @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(ph(i), 0);
            `CHECK(sw(i), step_of(i));
        end
        @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(ph(i), ftw_of(i));
            snap[i] = ph(i);
        end
        repeat (4) @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(ph(i) - snap[i], 4 * ftw_of(i));
        end
        i_host.read_reg(8'h24, rd_val);
        `CHECK(rd_val, ftw_of(1));
        i_host.read_reg(8'h38, rd_val);
        `CHECK(rd_val, step_of(2));
        i_host.write_reg(dbuc_pkg::ADDR_ACC_CTL, 32'h0000_0002);
        i_host.pulse_update(1'b1);
        repeat (2) @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(ph(i), 0);
            snap[i] = sw(i);
        end
        repeat (5) @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(ph(i), 0);
            `CHECK(sw(i) - snap[i], 5 * step_of(i));
        end
        i_host.write_reg(dbuc_pkg::ADDR_ACC_CTL, 32'h0000_0000);
        i_host.pulse_update(1'b0);
        repeat (3) @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(ph(i), 3 * ftw_of(i));
        end
        // Sweep side: auto-clear once, then hold-clear
        i_host.write_reg(dbuc_pkg::ADDR_ACC_CTL, 32'h0000_0004);
        i_host.pulse_update(1'b1);
        @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(sw(i), 0);
        end
        @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(sw(i), step_of(i));
        end
        i_host.write_reg(dbuc_pkg::ADDR_ACC_CTL, 32'h0000_0008);
        i_host.pulse_update(1'b0);
        i_host.read_reg(dbuc_pkg::ADDR_ACC_CTL, rd_val);
        `CHECK(rd_val, 8);
        repeat (3) @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) begin
            `CHECK(sw(i), 0);
        end
        close_out();
    end
endmodule // dbuc_top_bench
